// *** verilog/ict_ide_timing.sv ***
// Module: top of the IDE channel timing control block
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Two 16-bit timing words, primary and secondary, both reset to zero.
// - Decode enable set: claim the channel's ATA blocks and run them.
// - Decode enable clear: do not claim; flag the access subtractive.
// - Slave timing enable set: drive 1 takes counts from slave inputs.
// - Slave timing enable clear: this word's counts serve both drives.
// - Sample point code 00..11 gives 5,4,3,2 clocks to first ready sample.
// - Recovery code 00..11 gives 4,3,2,1 clocks before the next strobe.
// - Drive 1 DMA-only bit: fast timing for DMA only, PIO stays compatible.
// - Drive 1 prefetch bit enables prefetch and posting on the data port.
// - Drive 1 ready enable clear: internal ready forced asserted.
// - Shadow drive bit picks the drive whose ready enable applies.
// - Fast bank bit: data port uses fast path; others 8-bit compatible.
// - Drive 0 has the same four controls in bits 3:0.
module ict_ide_timing (
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_N,
  input  wire ict_pkg::ict_cfg_req_s CFG,
  output logic [31:0]               CFG_RDATA,
  input  wire ict_pkg::ict_slave_timing_s SLAVE_PRI,
  input  wire ict_pkg::ict_slave_timing_s SLAVE_SEC,
  input  wire ict_pkg::ict_io_req_s  IO,
  output logic                      IO_READY,
  output logic                      IO_CLAIM,
  output logic                      IO_SUBTRACTIVE,
  output logic                      IO_SECONDARY,
  output ict_pkg::ict_timing_s      IO_TIMING,
  output logic                      IO_STROBE_N,
  output logic                      IO_DONE,
  input  wire logic                 IORDY
);
  import ict_pkg::*;

  ict_top_state_s s;
  ict_top_state_s next_s;
  logic           cfg_hit;
  logic           claim_pri;
  logic           claim_sec;
  logic           sub_pri;
  logic           sub_sec;
  logic           take_pri;
  logic           take_sec;
  logic           rdy_eff;
  ict_timing_s    tm_pri;
  ict_timing_s    tm_sec;

  // ****************************************************
  // Channel decoders
  // ****************************************************
  ict_channel #(
    .CMD_BASE (ICT_CMD_BASE_PRI),
    .CTL_BASE (ICT_CTL_BASE_PRI)
  ) u_pri (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .cfg      (s.pri),
    .slave    (SLAVE_PRI),
    .io       (IO),
    .take     (take_pri),
    .claim    (claim_pri),
    .subtract (sub_pri),
    .timing   (tm_pri)
  );

  ict_channel #(
    .CMD_BASE (ICT_CMD_BASE_SEC),
    .CTL_BASE (ICT_CTL_BASE_SEC)
  ) u_sec (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .cfg      (s.sec),
    .slave    (SLAVE_SEC),
    .io       (IO),
    .take     (take_sec),
    .claim    (claim_sec),
    .subtract (sub_sec),
    .timing   (tm_sec)
  );

  // ****************************************************
  // Handshake and outputs
  // ****************************************************
  // Requests taken only while the engine is idle
  assign IO_READY       = (s.st == ICT_ST_IDLE);
  assign IO_CLAIM       = claim_pri | claim_sec;
  assign IO_SUBTRACTIVE = sub_pri | sub_sec;
  assign take_pri       = IO.req & IO_READY & claim_pri;
  assign take_sec       = IO.req & IO_READY & claim_sec;
  assign cfg_hit        = CFG.sel &&
                          (CFG.addr[7:2] == ICT_OFS_TIM_PRI[7:2]);

  // Registered outputs
  assign CFG_RDATA    = s.rdata;
  assign IO_SECONDARY = s.chan;
  assign IO_TIMING    = s.tm;
  assign IO_STROBE_N  = ~s.strobe;
  assign IO_DONE      = s.done;

  // Ready seen asserted when sampling is off for the drive
  assign rdy_eff = ~s.tm.sample_rdy | s.rdy_sync;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_s          = s;
    next_s.done     = 1'b0;
    next_s.rdy_meta = IORDY;
    next_s.rdy_sync = s.rdy_meta;

    // Config writes per byte lane, reserved bits dropped
    if (cfg_hit && CFG.wr) begin
      next_s.pri = ict_merge16(s.pri, CFG.wdata[15:0],
                               CFG.be[1:0]);
      next_s.sec = ict_merge16(s.sec, CFG.wdata[31:16],
                               CFG.be[3:2]);
    end

    // Config reads, zero outside the timing words
    if (CFG.sel && CFG.rd) begin
      next_s.rdata = cfg_hit ? {s.sec, s.pri} : 32'h00000000;
    end

    // Strobe engine
    case (s.st)
      ICT_ST_IDLE: begin
        if (take_pri || take_sec) begin
          next_s.chan   = take_sec;
          next_s.tm     = take_sec ? tm_sec : tm_pri;
          next_s.cnt    = take_sec ? tm_sec.sample_clks :
                                     tm_pri.sample_clks;
          next_s.strobe = 1'b1;
          next_s.st     = ICT_ST_STROBE;
        end
      end
      ICT_ST_STROBE: begin
        if (s.cnt > 3'h1) begin
          next_s.cnt = s.cnt - 3'h1;
        end else if (rdy_eff) begin
          // Last sample point: end strobe, start recovery
          next_s.strobe = 1'b0;
          next_s.done   = 1'b1;
          next_s.cnt    = s.tm.recover_clks;
          next_s.st     = ICT_ST_RECOVER;
        end
      end
      ICT_ST_RECOVER: begin
        if (s.cnt > 3'h1) begin
          next_s.cnt = s.cnt - 3'h1;
        end else begin
          next_s.st = ICT_ST_IDLE;
        end
      end
      default: begin
        next_s.st     = ICT_ST_IDLE;
        next_s.strobe = 1'b0;
      end
    endcase
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s     <= '0;
      s.pri <= ICT_TIM_RESET;
      s.sec <= ICT_TIM_RESET;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// *** verilog/ict_pkg.sv ***
// Package: constants and types of the IDE channel timing control block
package ict_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0]  ICT_OFS_TIM_PRI  = 8'h40;   // Primary cable word
  localparam logic [7:0]  ICT_OFS_TIM_SEC  = 8'h42;   // Secondary cable word
  localparam logic [15:0] ICT_TIM_RESET    = 16'h0000;
  localparam logic [15:0] ICT_TIM_WMASK    = 16'hf3ff; // Bits 11:10 held 0

  // ****************************************************
  // Field positions of a channel timing word
  // ****************************************************
  localparam int ICT_POS_DECODE_EN   = 15;
  localparam int ICT_POS_SLAVE_TIM   = 14;
  localparam int ICT_POS_SAMPLE_PT   = 12;
  localparam int ICT_POS_RECOVERY    = 8;
  localparam int ICT_POS_DRV1        = 4;
  localparam int ICT_POS_DRV0        = 0;

  // ****************************************************
  // ATA block addresses and ports
  // ****************************************************
  localparam logic [15:0] ICT_CMD_BASE_PRI = 16'h01f0;
  localparam logic [15:0] ICT_CTL_BASE_PRI = 16'h03f6;
  localparam logic [15:0] ICT_CMD_BASE_SEC = 16'h0170;
  localparam logic [15:0] ICT_CTL_BASE_SEC = 16'h0376;
  localparam logic [2:0]  ICT_PORT_DATA    = 3'h0;
  localparam logic [2:0]  ICT_PORT_DRVHEAD = 3'h6;
  localparam int          ICT_DRV_SEL_BIT  = 4;

  // ****************************************************
  // Timing counts in clocks
  // ****************************************************
  localparam logic [2:0]  ICT_SAMPLE_MAX   = 3'h5;   // Code 00 = 5 clocks
  localparam logic [2:0]  ICT_RECOVER_MAX  = 3'h4;   // Code 00 = 4 clocks

  // ****************************************************
  // Types
  // ****************************************************
  typedef struct packed {
    logic       decode_en;
    logic       slave_timing_enable;
    logic [1:0] ready_sample_point;
    logic [1:0] reserved;
    logic [1:0] recovery_time;
    logic       dma_only_fast_d1;
    logic       prefetch_post_d1;
    logic       ready_sample_en_d1;
    logic       fast_bank_d1;
    logic       dma_only_fast_d0;
    logic       prefetch_post_d0;
    logic       ready_sample_en_d0;
    logic       fast_bank_d0;
  } ict_chan_timing_s;

  typedef struct packed {
    logic [1:0] ready_sample_point;
    logic [1:0] recovery_time;
  } ict_slave_timing_s;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ict_cfg_req_s;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic        wr;
    logic        dma;
    logic [7:0]  wdata;
  } ict_io_req_s;

  typedef struct packed {
    logic [2:0] sample_clks;
    logic [2:0] recover_clks;
    logic       fast;
    logic       wide;
    logic       prefetch;
    logic       sample_rdy;
  } ict_timing_s;

  typedef enum logic [1:0] {
    ICT_ST_IDLE    = 2'b00,
    ICT_ST_STROBE  = 2'b01,
    ICT_ST_RECOVER = 2'b10
  } ict_state_e;

  typedef struct packed {
    logic drv_sel;
  } ict_chan_state_s;

  typedef struct packed {
    ict_chan_timing_s pri;
    ict_chan_timing_s sec;
    logic [31:0]      rdata;
    ict_state_e       st;
    logic [2:0]       cnt;
    ict_timing_s      tm;
    logic             chan;
    logic             strobe;
    logic             done;
    logic             rdy_meta;
    logic             rdy_sync;
  } ict_top_state_s;

  // ****************************************************
  // Functions
  // ****************************************************
  // Sample point code to clocks
  function automatic logic [2:0] ict_sample_clks(input logic [1:0] code);
    ict_sample_clks = ICT_SAMPLE_MAX - {1'b0, code};
  endfunction

  // Recovery code to clocks
  function automatic logic [2:0] ict_recover_clks(input logic [1:0] code);
    ict_recover_clks = ICT_RECOVER_MAX - {1'b0, code};
  endfunction

  // Byte-lane merge of a timing word, reserved bits forced low
  function automatic logic [15:0] ict_merge16(input logic [15:0] old,
                                              input logic [15:0] wd,
                                              input logic [1:0]  be);
    logic [15:0] m;
    m = old;
    if (be[0]) begin
      m[7:0] = wd[7:0];
    end
    if (be[1]) begin
      m[15:8] = wd[15:8];
    end
    ict_merge16 = m & ICT_TIM_WMASK;
  endfunction

endpackage

// *** verilog/ict_channel.sv ***
// Module: per-cable decode, drive tracking and timing resolution
`timescale 1ns/100ps
`default_nettype none
module ict_channel #(
  parameter logic [15:0] CMD_BASE = 16'h01f0,
  parameter logic [15:0] CTL_BASE = 16'h03f6
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire ict_pkg::ict_chan_timing_s  cfg,
  input  wire ict_pkg::ict_slave_timing_s slave,
  input  wire ict_pkg::ict_io_req_s       io,
  input  wire logic              take,
  output logic                   claim,
  output logic                   subtract,
  output ict_pkg::ict_timing_s   timing
);
  import ict_pkg::*;

  ict_chan_state_s s;
  ict_chan_state_s next_s;
  logic            cmd_hit;
  logic            ctl_hit;
  logic            data_port;
  logic            d1;
  logic            use_slave;
  logic            fast_bank;
  logic            dma_only;

  // ****************************************************
  // Address decode
  // ****************************************************
  // Command block of eight ports, control block of two
  assign cmd_hit   = io.addr[15:3] == CMD_BASE[15:3];
  assign ctl_hit   = io.addr[15:1] == CTL_BASE[15:1];
  assign data_port = cmd_hit && (io.addr[2:0] == ICT_PORT_DATA);
  assign claim     = (cmd_hit | ctl_hit) & cfg.decode_en;
  assign subtract  = (cmd_hit | ctl_hit) & ~cfg.decode_en;

  // ****************************************************
  // Timing resolution for the selected drive
  // ****************************************************
  // Drive 1 is the slave, drive 0 the master
  assign d1        = s.drv_sel;
  assign use_slave = cfg.slave_timing_enable & d1;
  assign fast_bank = d1 ? cfg.fast_bank_d1 : cfg.fast_bank_d0;
  assign dma_only  = d1 ? cfg.dma_only_fast_d1 : cfg.dma_only_fast_d0;

  // Counts, path width, prefetch and ready sampling
  always_comb begin
    timing.sample_clks  = use_slave ?
      ict_sample_clks(slave.ready_sample_point) :
      ict_sample_clks(cfg.ready_sample_point);
    timing.recover_clks = use_slave ?
      ict_recover_clks(slave.recovery_time) :
      ict_recover_clks(cfg.recovery_time);
    timing.fast = fast_bank &&
      ((io.dma && data_port) || (data_port && !dma_only));
    timing.wide = data_port;
    timing.prefetch = data_port &&
      (d1 ? cfg.prefetch_post_d1 : cfg.prefetch_post_d0);
    timing.sample_rdy = d1 ? cfg.ready_sample_en_d1 :
                             cfg.ready_sample_en_d0;
  end

  // ****************************************************
  // Drive select shadow
  // ****************************************************
  // Copy of drive bit on writes to the drive/head port
  always_comb begin
    next_s = s;
    if (take && io.wr && cmd_hit &&
        (io.addr[2:0] == ICT_PORT_DRVHEAD)) begin
      next_s.drv_sel = io.wdata[ICT_DRV_SEL_BIT];
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// *** testbench/ict_ide_timing_chk.sv ***
// Checker: port assertions of the IDE channel timing block
`timescale 1ns/100ps
`default_nettype none
module ict_ide_timing_chk (
  input wire logic                  REF_CLK,
  input wire logic                  RST_N,
  input wire ict_pkg::ict_cfg_req_s CFG,
  input wire logic [31:0]           CFG_RDATA,
  input wire ict_pkg::ict_io_req_s  IO,
  input wire logic                  IO_READY,
  input wire logic                  IO_CLAIM,
  input wire logic                  IO_SUBTRACTIVE,
  input wire ict_pkg::ict_timing_s  IO_TIMING,
  input wire logic                  IO_STROBE_N,
  input wire logic                  IO_DONE
);
  import ict_pkg::*;
  logic [5:0] low_cnt;
  logic [6:0] gap;
  logic [2:0] last_rec;
  // ****************
  // Strobe length and gap since sample edge
  // ****************
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt  <= 6'h00;
      gap      <= 7'h7f;
      last_rec <= 3'h0;
    end else begin
      low_cnt <= IO_STROBE_N ? 6'h00 : low_cnt + 6'h01;
      gap     <= IO_DONE ? 7'h01 : gap + {6'h00, gap != 7'h7f};
      if (IO_DONE) begin
        last_rec <= IO_TIMING.recover_clks;
      end
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  AST_TAKE_STROBE: assert property (
    IO.req && IO_READY && IO_CLAIM |=> !IO_STROBE_N)
    else $error("no strobe after claim");
  AST_SUB_IDLE: assert property (
    IO.req && IO_READY && IO_SUBTRACTIVE |=> IO_STROBE_N && IO_READY)
    else $error("strobe on subtractive access");
  AST_CLAIM_EXCL: assert property (!(IO_CLAIM && IO_SUBTRACTIVE))
    else $error("claim and subtractive together");
  AST_SAMPLE_LEN: assert property ($rose(IO_STROBE_N) |->
    (IO_TIMING.sample_rdy ? low_cnt >= {3'h0, IO_TIMING.sample_clks}
                          : low_cnt == {3'h0, IO_TIMING.sample_clks}))
    else $error("strobe length wrong");
  AST_DONE_EDGE: assert property (IO_DONE == $rose(IO_STROBE_N))
    else $error("done not at strobe end");
  AST_RECOVERY: assert property (
    $fell(IO_STROBE_N) |-> gap > {4'h0, last_rec})
    else $error("recovery too short");
  AST_BUSY: assert property (!IO_STROBE_N |-> !IO_READY)
    else $error("ready during strobe");
  AST_RSVD_ZERO: assert property (CFG.sel && CFG.rd |=>
    CFG_RDATA[11:10] == 2'h0 && CFG_RDATA[27:26] == 2'h0)
    else $error("reserved bits read nonzero");
  AST_UNMAPPED: assert property (
    CFG.sel && CFG.rd && CFG.addr[7:2] != 6'h10 |=> CFG_RDATA == 32'h0)
    else $error("unmapped read nonzero");
  AST_FAST_DATA: assert property (IO_TIMING.fast |-> IO_TIMING.wide)
    else $error("fast on non-data port");
  cover property ($rose(IO_STROBE_N) && IO_TIMING.sample_rdy);
  cover property (IO.req && IO_SUBTRACTIVE);
  cover property ($rose(IO_TIMING.fast));
endmodule
bind ict_ide_timing ict_ide_timing_chk chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .CFG(CFG), .CFG_RDATA(CFG_RDATA),
  .IO(IO), .IO_READY(IO_READY), .IO_CLAIM(IO_CLAIM),
  .IO_SUBTRACTIVE(IO_SUBTRACTIVE), .IO_TIMING(IO_TIMING),
  .IO_STROBE_N(IO_STROBE_N), .IO_DONE(IO_DONE)
);
`default_nettype wire

// *** testbench/ict_drive_model.sv ***
// Partner: IDE drive holding ready low a set number of clocks
`timescale 1ns/100ps
`default_nettype none
module ict_drive_model (
  input  wire logic       clk,
  input  wire logic       strobe_n,
  input  wire logic [3:0] wait_clks,
  output logic            iordy
);
  import ict_pkg::*;
  logic [3:0] held;
  // Clocks since strobe went low, saturating
  always_ff @(posedge clk) begin
    if (strobe_n) begin
      held <= 4'h0;
    end else if (held != 4'hf) begin
      held <= held + 4'h1;
    end
  end
  // Pull-up while idle, low until the wait runs out
  assign iordy = strobe_n || (held >= wait_clks);
endmodule
`default_nettype wire

// *** testbench/ict_ide_timing_test.sv ***
// Testbench: config and I/O sequences of the IDE timing block
`timescale 1ns/100ps
`default_nettype none
module ict_ide_timing_test;
  import ict_pkg::*;
  logic              ref_clk;
  logic              rst_n;
  ict_cfg_req_s      cfg;
  logic [31:0]       cfg_rdata;
  ict_slave_timing_s slave_pri;
  ict_io_req_s       io;
  logic              io_ready;
  logic              io_claim;
  logic              io_sub;
  logic              io_sec;
  ict_timing_s       io_timing;
  logic              io_strobe_n;
  logic              io_done;
  logic              iordy;
  logic [3:0]        wait_clks;
  logic [31:0]       rd;
  logic [5:0]        low;
  int                mismatches;
  int                total_checks;
  // Word, dma, port, expected fast/wide/prefetch/sample flags
  logic [23:0]       tab [6] = '{24'h80100c, 24'h809004, 24'h80908c,
                                 24'h804006, 24'h801010, 24'h802005};
  ict_ide_timing dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .CFG(cfg), .CFG_RDATA(cfg_rdata),
    .SLAVE_PRI(slave_pri), .SLAVE_SEC(4'h0), .IO(io),
    .IO_READY(io_ready), .IO_CLAIM(io_claim), .IO_SUBTRACTIVE(io_sub),
    .IO_SECONDARY(io_sec), .IO_TIMING(io_timing),
    .IO_STROBE_N(io_strobe_n), .IO_DONE(io_done), .IORDY(iordy));
  ict_drive_model drive (.clk(ref_clk), .strobe_n(io_strobe_n),
    .wait_clks(wait_clks), .iordy(iordy));
  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Config access, one cycle strobe then one idle cycle
  task automatic cfg_acc(input logic w, input logic [7:0] a,
                         input logic [3:0] be, input logic [31:0] d);
    cfg = '{sel: 1'b1, wr: w, rd: !w, addr: a, be: be, wdata: d};
    @(negedge ref_clk);
    cfg = '0;
    rd = cfg_rdata;
    @(negedge ref_clk);
  endtask
  // Claimed I/O access, counts strobe-low clocks until done
  task automatic io_acc(input logic [15:0] a, input logic w,
                        input logic dma, input logic [7:0] d);
    int n;
    low = 6'h00;
    for (n = 0; n < 50 && io_ready !== 1'b1; n++) @(negedge ref_clk);
    if (n == 50) begin
      mismatches++;
      tally_and_finish;
    end
    io = '{req: 1'b1, addr: a, wr: w, dma: dma, wdata: d};
    @(negedge ref_clk);
    io.req = 1'b0;
    for (n = 0; n < 50 && io_done !== 1'b1; n++) begin
      if (io_strobe_n === 1'b0) low++;
      @(negedge ref_clk);
    end
    if (n == 50) begin
      mismatches++;
      tally_and_finish;
    end
  endtask
  initial begin
    rst_n = 1'b0;
    cfg = '0;
    io = '0;
    slave_pri = 4'h0;
    wait_clks = 4'h0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    cfg_acc(1'b0, 8'h40, 4'hf, 32'h0);
    chk("reset", 32'h0, rd);
    cfg_acc(1'b1, 8'h40, 4'hf, 32'hffffffff);
    cfg_acc(1'b0, 8'h40, 4'hf, 32'h0);
    chk("rsvd", 32'hf3fff3ff, rd);
    cfg_acc(1'b1, 8'h40, 4'h2, 32'h0);
    cfg_acc(1'b0, 8'h44, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    cfg_acc(1'b0, 8'h40, 4'hf, 32'h0);
    chk("bytes", 32'hf3ff00ff, rd);
    io = '{req: 1'b1, addr: 16'h01f0, wr: 1'b0, dma: 1'b0, wdata: 8'h0};
    repeat (3) @(negedge ref_clk);
    chk("sub", 32'h3, {29'h0, io_claim, io_sub, io_strobe_n});
    io.req = 1'b0;
    io_acc(16'h0170, 1'b0, 1'b0, 8'h0);
    chk("sec", 32'h10917, 32'({io_sec, low, io_timing}));
    chk("claim", 32'h1, 32'(io_claim));
    io_acc(16'h0170, 1'b0, 1'b1, 8'h0);
    chk("dma", 32'h1, 32'(io_timing.fast));
    wait_clks = 4'h6;
    for (int k = 0; k < 4; k++) begin
      cfg_acc(1'b1, 8'h40, 4'h3, 32'h8000 | 32'(k * 16'h1100));
      io_acc(16'h01f0, 1'b0, 1'b0, 8'h0);
      io_acc(16'h01f0, 1'b1, 1'b0, 8'h0);
      chk("sample", 32'(5 - k), 32'(low));
      chk("recover", 32'(4 - k), 32'(io_timing.recover_clks));
    end
    cfg_acc(1'b1, 8'h40, 4'h3, 32'h8002);
    io_acc(16'h01f0, 1'b0, 1'b0, 8'h0);
    chk("wait", 32'h1, 32'(low > 6'h05));
    io_acc(16'h01f6, 1'b1, 1'b0, 8'h10);
    io_acc(16'h01f0, 1'b0, 1'b0, 8'h0);
    chk("other drive", 32'h5, 32'(low));
    wait_clks = 4'h0;
    slave_pri = 4'hf;
    cfg_acc(1'b1, 8'h40, 4'h3, 32'hc000);
    io_acc(16'h01f0, 1'b0, 1'b0, 8'h0);
    chk("slave on", 32'h11, 32'(io_timing[9:4]));
    cfg_acc(1'b1, 8'h40, 4'h3, 32'h8000);
    io_acc(16'h01f0, 1'b0, 1'b0, 8'h0);
    chk("slave off", 32'h2c, 32'(io_timing[9:4]));
    foreach (tab[i]) begin
      cfg_acc(1'b1, 8'h40, 4'h3, {16'h0, tab[i][23:8]});
      io_acc(16'h01f0 | 16'(tab[i][6:4]), 1'b0, tab[i][7], 8'h0);
      chk("drive1", 32'(tab[i][3:0]), 32'(io_timing[3:0]));
    end
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_n = 1'b1;
    cfg_acc(1'b0, 8'h40, 4'hf, 32'h0);
    chk("rereset", 32'h0, rd);
    tally_and_finish;
  end
endmodule
`default_nettype wire
